// ==== src/brf_report.sv ====
// Brightness reporting, calibration, walking test and function block enables.
`timescale 1ns/1ns
`default_nettype none
`include "brf_consts.svh"
module brf_report #(
	parameter int CLK_PER_SEC = `BRF_CLK_PER_SEC
) (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// Wishbone slave.
	input  wire brf_pkg::brf_wb_req_s wb_req,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o,
	// Sensor side.
	input  wire logic [15:0]          meas_lux,
	input  wire logic                 meas_vld,
	input  wire logic                 pir_motion,
	// Infrared remote commands and bus read request.
	input  wire logic                 ir_walk_on,
	input  wire logic                 ir_walk_off,
	input  wire logic                 read_req,
	// Outputs.
	output logic                      tx_vld,
	output logic [15:0]               tx_val,
	output logic                      led_blue,
	output logic [4:0]                fb_en,
	output logic                      eval_en
);
	// ----------------------------------------------------------------
	// Helper functions.
	// ----------------------------------------------------------------
	// Byte-lane merge for partial writes.
	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction
	// Clamp a 6-bit setting into a range.
	function automatic logic [5:0] clamp6(input logic [5:0] v, input logic [5:0] lo,
		input logic [5:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	// Absolute difference of two brightness words.
	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? (a - b) : (b - a);
	endfunction
	// ----------------------------------------------------------------
	// Register file and bus decode.
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_r;     // Mode, calibration and display settings.
	logic [5:0]  thr_r;      // Threshold in 5 lux steps.
	logic [5:0]  min_r;      // Cycle minutes.
	logic [5:0]  sec_r;      // Cycle seconds.
	logic [3:0]  use_r;      // Enables of blocks two to five.
	logic [9:0]  grp_r;      // Two group bits per block.
	logic [15:0] cal_ref_r;  // Last reference brightness written.
	logic [15:0] gain_cal_r; // Calibrated gain, Q8.8.
	logic        cal_done_r; // A user calibration has been received.
	logic        walk_r;     // Walking test active.
	logic [15:0] bright_r;   // Brightness object value.
	logic [15:0] meas_r;     // Latest raw measurement.
	logic        have_r;     // At least one measurement seen.
	logic        ack_r;      // Bus acknowledge.
	logic [31:0] rdat_r;     // Bus read data.
	wire         acc    = wb_req.cyc & wb_req.stb;
	wire [5:0]   widx   = wb_req.adr[7:2];
	// Writes land on the edge at which the master samples ack.
	wire         wr     = acc & wb_req.we & ack_r;
	wire         wr_ctl = wr & (widx == `BRF_OFS_CTRL >> 2);
	wire         wr_thr = wr & (widx == `BRF_OFS_THR >> 2);
	wire         wr_cyc = wr & (widx == `BRF_OFS_CYCLE >> 2);
	wire         wr_fb  = wr & (widx == `BRF_OFS_FBCFG >> 2);
	wire         wr_cal = wr & (widx == `BRF_OFS_CAL >> 2);
	wire         wr_cmd = wr & (widx == `BRF_OFS_CMD >> 2);
	wire [31:0]  cur_thr = {26'h0, thr_r};
	wire [31:0]  cur_cyc = {18'h0, min_r, 2'h0, sec_r};
	wire [31:0]  cur_fb  = {14'h0, grp_r, 3'h0, use_r, 1'b1};
	wire [31:0]  n_ctl   = wmerge({24'h0, ctrl_r}, wb_req.dat, wb_req.sel);
	wire [31:0]  n_thr   = wmerge(cur_thr, wb_req.dat, wb_req.sel);
	wire [31:0]  n_cyc   = wmerge(cur_cyc, wb_req.dat, wb_req.sel);
	wire [31:0]  n_fb    = wmerge(cur_fb, wb_req.dat, wb_req.sel);
	wire [31:0]  n_cal   = wmerge({16'h0, cal_ref_r}, wb_req.dat, wb_req.sel);
	// Command bits are pulses; unselected lanes give no command.
	wire         prog    = wr_cmd & wb_req.sel[0] & wb_req.dat[0];
	wire         b_on    = wr_cmd & wb_req.sel[0] & wb_req.dat[1];
	wire         b_off   = wr_cmd & wb_req.sel[0] & wb_req.dat[2];
	// Control fields.
	wire [1:0]   mode    = ctrl_r[1:0];
	wire         cal_sel = ctrl_r[2];
	wire         pend_tx = ctrl_r[3];
	wire         wt_prog = ctrl_r[4];
	wire         led_nrm = ctrl_r[5];
	wire         grp_en  = ctrl_r[6];
	wire         act_g2  = ctrl_r[7];
	wire [6:0]   stat    = {walk_r, cal_done_r, fb_en};
	// Read data selection; unmapped offsets read as zero.
	wire [31:0]  rd_mux  =
		(widx == `BRF_OFS_CTRL >> 2)   ? {24'h0, ctrl_r} :
		(widx == `BRF_OFS_THR >> 2)    ? cur_thr :
		(widx == `BRF_OFS_CYCLE >> 2)  ? cur_cyc :
		(widx == `BRF_OFS_FBCFG >> 2)  ? cur_fb :
		(widx == `BRF_OFS_CAL >> 2)    ? {16'h0, cal_ref_r} :
		(widx == `BRF_OFS_BRIGHT >> 2) ? {16'h0, bright_r} :
		(widx == `BRF_OFS_STAT >> 2)   ? {25'h0, stat} : 32'h0;
	// Single-wait-state acknowledge; dropped in the cycle after it is given.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h0;
		end else begin
			ack_r  <= acc & ~ack_r;
			rdat_r <= rd_mux;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	// Settings registers; out-of-range values are clamped on write.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_r <= `BRF_CTRL_RST;
			thr_r  <= `BRF_THR_RST;
			min_r  <= `BRF_MIN_RST;
			sec_r  <= `BRF_SEC_RST;
			use_r  <= 4'h0;
			grp_r  <= 10'h0;
		end else begin
			if (wr_ctl) begin
				ctrl_r <= n_ctl[7:0];
			end
			if (wr_thr) begin
				thr_r <= clamp6(n_thr[5:0], `BRF_THR_MIN, `BRF_THR_MAX);
			end
			if (wr_cyc) begin
				sec_r <= clamp6(n_cyc[5:0], 6'h0, `BRF_CYC_MAX);
				min_r <= clamp6(n_cyc[13:8], 6'h0, `BRF_CYC_MAX);
			end
			if (wr_fb) begin
				use_r <= n_fb[4:1];
				grp_r <= n_fb[`BRF_GRP_LSB +: 10];
			end
		end
	end
	// ----------------------------------------------------------------
	// Measurement and calibration.
	// ----------------------------------------------------------------
	// The reference is related to the measurement held when the word arrives.
	// A zero measurement gives the largest gain rather than a divide fault.
	wire [23:0] n_ref_q = {n_cal[15:0], 8'h0};
	wire [23:0] quot    = (meas_r == 16'h0) ? 24'hffffff : n_ref_q / {8'h0, meas_r};
	wire [15:0] gain_nxt = (quot > 24'h00ffff) ? 16'hffff : quot[15:0];
	wire [15:0] gain    = cal_sel ? gain_cal_r : `BRF_GAIN_FACT;
	wire [31:0] prod    = meas_r * gain;
	wire [23:0] surf_w  = prod[31:8];
	wire [15:0] surf    = (surf_w > {8'h0, `BRF_SAT}) ? `BRF_SAT : surf_w[15:0];
	wire        pend    = cal_sel & ~cal_done_r;
	assign eval_en = ~pend;
	// Calibration state; a calibration written while none is selected is kept.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cal_ref_r  <= 16'h0;
			gain_cal_r <= `BRF_GAIN_FACT;
			cal_done_r <= 1'b0;
			meas_r     <= 16'h0;
			have_r     <= 1'b0;
		end else begin
			if (meas_vld) begin
				meas_r <= meas_lux;
				have_r <= 1'b1;
			end
			if (wr_cal) begin
				cal_ref_r  <= n_cal[15:0];
				gain_cal_r <= gain_nxt;
				cal_done_r <= 1'b1;
			end
		end
	end
	// ----------------------------------------------------------------
	// Transmission scheduling.
	// ----------------------------------------------------------------
	logic [15:0] last_r;  // Last transmitted value.
	logic        sent_r;  // Something was sent since restart.
	logic [31:0] pre_r;   // Cycles within the current second.
	logic [11:0] secs_r;  // Seconds since the last transmission.
	wire [15:0] val     = pend ? (pend_tx ? `BRF_INVALID : 16'h0) : surf;
	wire        can_tx  = have_r & (~pend | pend_tx);
	wire        chg_m   = (mode == brf_pkg::BRF_ON_CHANGE) | (mode == brf_pkg::BRF_BOTH);
	wire        cyc_m   = (mode == brf_pkg::BRF_CYCLIC) | (mode == brf_pkg::BRF_BOTH);
	wire [15:0] thr_lux = 16'({10'h0, thr_r} * `BRF_LUX_STEP);
	wire [11:0] ivl     = 12'(min_r * 12'd60) + {6'h0, sec_r};
	wire        tick    = (pre_r == 32'(CLK_PER_SEC - 1));
	// Outside the change modes the threshold is never looked at.
	wire        moved   = pend ? (val != last_r) : (absdiff(val, last_r) >= thr_lux);
	wire        chg_hit = chg_m & can_tx & (~sent_r | moved);
	wire        cyc_hit = cyc_m & can_tx & tick & (ivl != 12'h0) & (secs_r + 12'h1 >= ivl);
	// Passive mode answers read requests only.
	wire        rd_hit  = read_req & can_tx;
	wire        tx_go   = chg_hit | cyc_hit | rd_hit;
	// Each send restarts the interval and becomes the new reference.
	always_ff @(posedge clk) begin
		if (!rstn || prog) begin
			last_r <= 16'h0;
			sent_r <= 1'b0;
			pre_r  <= 32'h0;
			secs_r <= 12'h0;
			tx_vld <= 1'b0;
			tx_val <= 16'h0;
		end else begin
			tx_vld <= tx_go;
			pre_r  <= tick ? 32'h0 : pre_r + 32'h1;
			if (tx_go) begin
				tx_val <= val;
				last_r <= val;
				sent_r <= 1'b1;
				secs_r <= 12'h0;
			end else if (tick) begin
				secs_r <= secs_r + 12'h1;
			end
		end
	end
	// Object value tracks the derived brightness, or zero or the marker while pending.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bright_r <= 16'h0;
		end else begin
			bright_r <= val;
		end
	end
	// ----------------------------------------------------------------
	// Walking test and status LED.
	// ----------------------------------------------------------------
	logic [2:0] pir_sync_r; // Three-stage synchroniser.
	logic       pir_r;      // Accepted motion level.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pir_sync_r <= 3'h0;
			pir_r      <= 1'b0;
		end else begin
			pir_sync_r <= {pir_sync_r[1:0], pir_motion};
			if (pir_sync_r[1] == pir_sync_r[2]) begin
				pir_r <= pir_sync_r[2];
			end
		end
	end
	// Programming takes precedence over remote commands in the same cycle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			walk_r <= 1'b0;
		end else if (prog) begin
			walk_r <= wt_prog;
		end else if (ir_walk_on | b_on) begin
			walk_r <= 1'b1;
		end else if (ir_walk_off | b_off) begin
			walk_r <= 1'b0;
		end
	end
	assign led_blue = pir_r & (walk_r | led_nrm);
	// ----------------------------------------------------------------
	// Function block enables.
	// ----------------------------------------------------------------
	wire [4:0] fb_use = {use_r, 1'b1};
	for (genvar i = 0; i < 5; i++) begin : g_fb
		wire [1:0] g   = grp_r[2*i +: 2];
		// Unassigned blocks, or switching unused, run on their own.
		wire       gok = ~grp_en | (g == brf_pkg::BRF_NO_GRP) |
			((g == brf_pkg::BRF_GRP1) & ~act_g2) | ((g == brf_pkg::BRF_GRP2) & act_g2);
		assign fb_en[i] = fb_use[i] & gok & eval_en;
	end
	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	chk_thr_range: assert property (@(posedge clk) disable iff (!rstn)
		thr_r >= `BRF_THR_MIN && thr_r <= `BRF_THR_MAX) else $error("threshold out of range");
	chk_cyc_fields: assert property (@(posedge clk) disable iff (!rstn)
		min_r <= `BRF_CYC_MAX && sec_r <= `BRF_CYC_MAX) else $error("cycle field above 59");
	chk_passive_quiet: assert property (@(posedge clk) disable iff (!rstn)
		tx_vld && $past(mode) == brf_pkg::BRF_PASSIVE && !$past(prog) |-> $past(read_req))
		else $error("passive mode sent without read");
	chk_change_send: assert property (@(posedge clk) disable iff (!rstn)
		chg_m && can_tx && sent_r && !pend && absdiff(val, last_r) >= thr_lux && !prog
		|=> tx_vld) else $error("change not sent");
	chk_factory_gain: assert property (@(posedge clk) disable iff (!rstn)
		!cal_sel |-> gain == `BRF_GAIN_FACT) else $error("factory gain wrong");
	chk_cal_taken: assert property (@(posedge clk) disable iff (!rstn)
		wr_cal |=> cal_done_r && cal_ref_r == $past(n_cal[15:0])) else $error("calibration lost");
	chk_pend_dead: assert property (@(posedge clk) disable iff (!rstn)
		pend |-> fb_en == 5'h0 && !eval_en) else $error("blocks live while pending");
	chk_pend_silent: assert property (@(posedge clk) disable iff (!rstn)
		pend && !pend_tx |-> !tx_go && (bright_r == 16'h0 || !$past(pend && !pend_tx)))
		else $error("pending value not silent");
	chk_walk_prog: assert property (@(posedge clk) disable iff (!rstn)
		prog |=> walk_r == $past(wt_prog)) else $error("walk test after programming");
	chk_walk_ir: assert property (@(posedge clk) disable iff (!rstn)
		ir_walk_on && !prog |=> walk_r) else $error("remote walk on ignored");
	chk_led_off: assert property (@(posedge clk) disable iff (!rstn)
		!walk_r && !led_nrm |-> !led_blue) else $error("led lit outside test");
	chk_fb1_on: assert property (@(posedge clk) disable iff (!rstn)
		eval_en && (!grp_en || grp_r[1:0] == 2'h0) |-> fb_en[0]) else $error("block one off");
	chk_ref_update: assert property (@(posedge clk) disable iff (!rstn)
		tx_vld |-> last_r == tx_val) else $error("reference not updated");
endmodule
`default_nettype wire

// ==== src/brf_consts.svh ====
// Constants for the brightness report and function block group logic.
// Function
// - Threshold 5 to 200 lux, steps 5, default 20.
// - Send on change when moved by threshold.
// - Cyclic resend, minutes and seconds 0..59, 3:00.
// - Modes change, cyclic, both, passive read only.
// - Factory calibration uses reflection coefficient 0.3.
// - Calibration word rescales measurement to reference.
// - Pending calibration disables evaluation and blocks.
// - Pending shows zero silently or sends 7FFF.
// - Walking test follows setting after programming.
// - Remote control switches walking test on/off.
// - Blue LED shows motion in test, optionally always.
// - First function block always enabled; the code still gates it by its group and by pending calibration.
// - Blocks two to five enabled individually.
// - Each block assigned none, group 1, group 2.
// - Unassigned blocks ignore group switching.
// - Blocks of inactive group are deactivated.
`ifndef BRF_CONSTS_SVH
`define BRF_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define BRF_OFS_CTRL   8'h00
`define BRF_OFS_THR    8'h04
`define BRF_OFS_CYCLE  8'h08
`define BRF_OFS_FBCFG  8'h0c
`define BRF_OFS_CAL    8'h10
`define BRF_OFS_BRIGHT 8'h14
`define BRF_OFS_STAT   8'h18
`define BRF_OFS_CMD    8'h1c
// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define BRF_CTRL_RST   8'h00
`define BRF_THR_MIN    6'h01
`define BRF_THR_MAX    6'h28
`define BRF_THR_RST    6'h04
`define BRF_LUX_STEP   16'h0005
`define BRF_CYC_MAX    6'h3b
`define BRF_MIN_RST    6'h03
`define BRF_SEC_RST    6'h00
`define BRF_GRP_LSB    8
`define BRF_MIN_LSB    8
`define BRF_GAIN_FACT  16'h0355
`define BRF_INVALID    16'h7fff
`define BRF_SAT        16'h7ffe
// ----------------------------------------------------------------
// Timing: one second expressed in clock cycles.
// ----------------------------------------------------------------
`define BRF_SEC_NS     1000000000
`define BRF_CLK_NS     10
`define BRF_CLK_PER_SEC (`BRF_SEC_NS / `BRF_CLK_NS)
`endif

// ==== src/brf_pkg.sv ====
// Types shared by the brightness report block.
package brf_pkg;
	// Reporting mode of the brightness value.
	typedef enum logic [1:0] {
		BRF_ON_CHANGE = 2'h0,
		BRF_CYCLIC    = 2'h1,
		BRF_BOTH      = 2'h2,
		BRF_PASSIVE   = 2'h3
	} brf_mode_e;
	// Group assignment of one function block.
	typedef enum logic [1:0] {
		BRF_NO_GRP = 2'h0,
		BRF_GRP1   = 2'h1,
		BRF_GRP2   = 2'h2
	} brf_grp_e;
	// Classic Wishbone request from the master.
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} brf_wb_req_s;
endpackage

// ==== tb/brf_bus_model.sv ====
// Behavioural model of the building bus subscribers facing the report block.
`timescale 1ns/1ns
`default_nettype none
module brf_bus_model (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rstn,
	// Telegrams from the device.
	input  wire logic        tx_vld,
	input  wire logic [15:0] tx_val,
	// Read request towards the device.
	output var  logic        read_req
);
	// ----------------------------------------------------------------
	// Telegram log
	// ----------------------------------------------------------------
	int          tx_cnt  = 0;        // Telegrams seen so far.
	logic [15:0] tx_last = 16'h0000; // Value of the latest telegram.

	initial read_req = 1'b0;

	// Every transmit strobe is one telegram on the bus.
	always @(posedge clk) begin
		if (tx_vld === 1'b1) begin
			tx_cnt  <= tx_cnt + 1;
			tx_last <= tx_val;
		end
	end

	// A read of the brightness object is a single request pulse.
	task automatic poll;
		@(posedge clk);
		read_req <= 1'b1;
		@(posedge clk);
		read_req <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/brf_report_tb_top.sv ====
// Self-checking bench for the brightness report block.
`timescale 1ns/1ns
`default_nettype none
module brf_report_tb_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                 clk        = 1'b0;
	logic                 rstn       = 1'b0;
	brf_pkg::brf_wb_req_s wb_req     = '0;
	logic [31:0]          wb_dat_o;
	logic                 wb_ack_o;
	logic [15:0]          meas_lux   = 16'h0000;
	logic                 meas_vld   = 1'b0;
	logic                 pir_motion = 1'b0;
	logic                 ir_walk_on = 1'b0;
	logic                 ir_walk_off = 1'b0;
	logic                 read_req;
	logic                 tx_vld;
	logic [15:0]          tx_val;
	logic                 led_blue;
	logic [4:0]           fb_en;
	logic                 eval_en;
	logic [31:0]          rd;        // Data of the last bus read.
	int                   err_count   = 0;
	int                   check_count = 0;
	int                   n0;        // Telegram count at a scenario start.
	int                   n;

	// A short second keeps the cyclic interval within a few hundred cycles.
	always #5 clk = ~clk;

	brf_report #(.CLK_PER_SEC(10)) dut (
		.clk(clk), .rstn(rstn), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.meas_lux(meas_lux), .meas_vld(meas_vld), .pir_motion(pir_motion),
		.ir_walk_on(ir_walk_on), .ir_walk_off(ir_walk_off), .read_req(read_req),
		.tx_vld(tx_vld), .tx_val(tx_val), .led_blue(led_blue), .fb_en(fb_en), .eval_en(eval_en)
	);

	brf_bus_model partner (
		.clk(clk), .rstn(rstn), .tx_vld(tx_vld), .tx_val(tx_val), .read_req(read_req)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic end_sim;
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Classic single cycle; ends at the falling edge so outputs have settled.
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_req <= '0;
		@(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask

	// One measurement strobe, then time for the telegram to appear.
	task automatic meas(input logic [15:0] v);
		@(posedge clk);
		meas_lux <= v;
		meas_vld <= 1'b1;
		@(posedge clk);
		meas_vld <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic rst;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
	endtask

	task automatic ir(input logic on);
		@(posedge clk);
		ir_walk_on  <= on;
		ir_walk_off <= ~on;
		@(posedge clk);
		ir_walk_on  <= 1'b0;
		ir_walk_off <= 1'b0;
	endtask

	// Surface brightness for a gain in 1/256 units, saturated below the marker.
	function automatic logic [15:0] surf(input logic [15:0] m, input logic [31:0] g);
		logic [31:0] p;
		p = (m * g) >> 8;
		return (p > 32'h7ffe) ? 16'h7ffe : p[15:0];
	endfunction

	// ----------------------------------------------------------------
	// Watchdog: the sequence needs well under 3000 cycles.
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		rst();
		rc(8'h00, 32'h0, "ctrl reset");
		rc(8'h04, 32'h4, "thr reset");
		rc(8'h08, 32'h0300, "cycle reset");
		rc(8'h0c, 32'h1, "fbcfg reset");
		rc(8'h20, 32'h0, "unmapped read");
		wr(8'h04, 32'h0);
		rc(8'h04, 32'h1, "thr low clamp");
		wr(8'h04, 32'h3f);
		rc(8'h04, 32'h28, "thr high clamp");
		wr(8'h08, 32'h3f3f);
		rc(8'h08, 32'h3b3b, "cycle clamp");
		// Every reporting mode can be selected.
		for (int m = 0; m < 4; m++) begin
			wr(8'h00, 32'(m));
			rc(8'h00, 32'(m), "mode");
		end
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h4);
		// On change: 13 lux below the 20 lux step is held back, 26 lux is sent.
		n0 = partner.tx_cnt;
		meas(16'd100);
		chk("first send", n0 + 1, partner.tx_cnt);
		chk("factory value", surf(16'd100, 32'h355), partner.tx_last);
		meas(16'd104);
		chk("small change", n0 + 1, partner.tx_cnt);
		meas(16'd108);
		chk("large change", n0 + 2, partner.tx_cnt);
		chk("change value", surf(16'd108, 32'h355), partner.tx_last);
		// Passive: only a read request answers.
		wr(8'h00, 32'h3);
		meas(16'd200);
		chk("passive quiet", n0 + 2, partner.tx_cnt);
		partner.poll();
		repeat (3) @(posedge clk);
		chk("read answer", n0 + 3, partner.tx_cnt);
		chk("read value", surf(16'd200, 32'h355), partner.tx_last);
		// Cyclic every 2 s of 10 cycles: about ten sends in 200 cycles.
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h1);
		repeat (30) @(posedge clk);
		n0 = partner.tx_cnt;
		repeat (200) @(posedge clk);
		n = partner.tx_cnt - n0;
		check_count++;
		if (n < 9 || n > 11) begin
			err_count++;
			$display("[ERR] cyclic sends expected 10 seen %0d", n);
		end
		// Both modes: a long interval leaves only the change path to send.
		wr(8'h08, 32'h3b3b);
		wr(8'h00, 32'h2);
		n0 = partner.tx_cnt;
		meas(16'd300);
		chk("both change", n0 + 1, partner.tx_cnt);
		chk("both value", surf(16'd300, 32'h355), partner.tx_last);
		// Walking test and the blue LED.
		rst();
		pir_motion <= 1'b1;
		repeat (6) @(negedge clk);
		chk("led normal", 32'h0, 32'(led_blue));
		wr(8'h1c, 32'h2);
		chk("led test on", 32'h1, 32'(led_blue));
		wr(8'h1c, 32'h4);
		chk("led test off", 32'h0, 32'(led_blue));
		wr(8'h00, 32'h20);
		chk("led always", 32'h1, 32'(led_blue));
		wr(8'h00, 32'h10);
		wr(8'h1c, 32'h1);
		rc(8'h18, 32'h41, "walk after prog");
		wr(8'h00, 32'h0);
		wr(8'h1c, 32'h1);
		rc(8'h18, 32'h01, "no walk after prog");
		ir(1'b1);
		rc(8'h18, 32'h41, "remote on");
		ir(1'b0);
		rc(8'h18, 32'h01, "remote off");
		@(posedge clk);
		pir_motion <= 1'b0;
		// Blocks 3 and 5 in use; block 1 in group 1, block 3 in group 2.
		wr(8'h0c, 32'h2114);
		rc(8'h0c, 32'h2115, "fbcfg");
		chk("fb use", 32'h15, 32'(fb_en));
		wr(8'h00, 32'h40);
		chk("fb group 1", 32'h11, 32'(fb_en));
		wr(8'h00, 32'hc0);
		chk("fb group 2", 32'h14, 32'(fb_en));
		// Calibration by telegram, silent while pending, then the marker with pending send on.
		rst();
		wr(8'h00, 32'h4);
		n0 = partner.tx_cnt;
		meas(16'd100);
		chk("pending quiet", n0, partner.tx_cnt);
		chk("eval off", 32'h0, 32'(eval_en));
		chk("pending blocks", 32'h0, 32'(fb_en));
		rc(8'h14, 32'h0, "pending object");
		wr(8'h00, 32'hc);
		meas(16'd100);
		chk("pending marker", 32'h7fff, partner.tx_last);
		wr(8'h10, 32'hc8);
		chk("eval on", 32'h1, 32'(eval_en));
		rc(8'h14, 32'hc8, "calibrated");
		meas(16'd150);
		chk("scaled send", 32'h12c, partner.tx_last);
		end_sim();
	end
endmodule
`default_nettype wire
